// ===== src/seg_clock_prescaler.sv
// display clock prescaler: one tick every 1024 << code oscillator cycles
// assumes one clock, halted by run_in low (counter then holds its value)
`timescale 1ns/1ns
`include "seg_display_params.svh"

module seg_clock_prescaler #(
  parameter int BASE_DIVIDE = `SEG_BASE_DIVIDE
) (
  input  wire logic       core_clk_in,
  input  wire logic       rst_in,
  input  wire logic       run_in,
  input  wire logic [2:0] prescale_in,
  output logic            tick_out
);

  logic [`SEG_DIV_WIDTH-1:0] count;
  logic [`SEG_DIV_WIDTH-1:0] limit;

  // divisor minus one for the selected code
  assign limit = `SEG_DIV_WIDTH'((BASE_DIVIDE << prescale_in) - 1);
  assign tick_out = run_in && (count >= limit);

  // free count, frozen while halted
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      count <= '0;
    end else if (tick_out) begin
      count <= '0;
    end else if (run_in) begin
      count <= count + 1'b1;
    end
  end

  chk_tick_spacing: assert property (@(posedge core_clk_in)
    disable iff (rst_in) tick_out |=> !tick_out [*2])
    else $error("prescaler ticks closer than its divisor");

endmodule // seg_clock_prescaler

// ===== src/seg_display_params.svh
// constants of the segment display driver: reset values, dividers, layout
// assumes inclusion by name from the package and the design modules
`ifndef SEG_DISPLAY_PARAMS_SVH
`define SEG_DISPLAY_PARAMS_SVH

// oscillator divide at prescale code 000; each code step doubles it
`define SEG_BASE_DIVIDE    1024
`define SEG_DIV_WIDTH      17
// reset values of the captured controls
`define SEG_DUTY_RESET     2'h0
`define SEG_BIAS_RESET     1'h0
`define SEG_PRESCALE_RESET 3'h0
`define SEG_FP_EN_RESET    32'h0000_0000
// segment memory shape and nibble layout
`define SEG_MEM_DEPTH      16
`define SEG_MEM_ADDR_W     4
`define SEG_NIBBLE_W       4
`define SEG_FP_COUNT       32
`define SEG_BP_COUNT       4

`endif

// ===== src/seg_display_pkg.sv
// types shared by the segment display driver modules
// assumes seg_display_params.svh on the include path
`include "seg_display_params.svh"

package seg_display_pkg;

  // drive level codes, v0 being driver ground and v3 the display supply
  typedef enum logic [1:0] {
    LEVEL_V0 = 2'b00,
    LEVEL_V1 = 2'b01,
    LEVEL_V2 = 2'b10,
    LEVEL_V3 = 2'b11
  } level_type;

  // duty field encoding
  typedef enum logic [1:0] {
    DUTY_QUARTER = 2'b00,
    DUTY_ONE     = 2'b01,
    DUTY_HALF    = 2'b10,
    DUTY_THIRD   = 2'b11
  } duty_type;

  // bias in force after duty and bias bit are combined
  typedef enum logic [1:0] {
    BIAS_FULL  = 2'b00,
    BIAS_HALF  = 2'b01,
    BIAS_THIRD = 2'b10
  } bias_type;

endpackage

// ===== src/seg_segment_memory.sv
// 16-byte segment memory: bus port plus a flat view for the waveform logic
// assumes synchronous bus strobes; contents are left uninitialised at reset
`timescale 1ns/1ns
`include "seg_display_params.svh"

module seg_segment_memory (
  input  wire logic                       core_clk_in,
  input  wire logic                       rst_in,
  input  wire logic [`SEG_MEM_ADDR_W-1:0] addr_in,
  input  wire logic                       write_in,
  input  wire logic                       read_in,
  input  wire logic [7:0]                 wdata_in,
  output logic      [7:0]                 rdata_out,
  output logic      [127:0]               seg_bits_out
);

  logic [7:0] mem [`SEG_MEM_DEPTH];

  // bus write at any time, no reset of contents
  always_ff @(posedge core_clk_in) begin
    if (write_in) begin
      mem[addr_in] <= wdata_in;
    end
  end

  // registered read data, held between reads
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_out <= 8'h00;
    end else if (read_in) begin
      rdata_out <= mem[addr_in];
    end
  end

  // byte n carries frontplanes 2n (low nibble) and 2n+1 (high nibble)
  for (genvar b = 0; b < `SEG_MEM_DEPTH; b++) begin : g_view
    assign seg_bits_out[8*b +: 8] = mem[b];
  end

  chk_write_readback: assert property (@(posedge core_clk_in)
    disable iff (rst_in)
    (write_in ##1 (read_in && !write_in && addr_in == $past(addr_in)))
    |=> rdata_out == $past(wdata_in, 2))
    else $error("segment memory read does not return written byte");

endmodule // seg_segment_memory

// ===== src/segment_display_driver.sv
// segment display driver: prescaler, backplane phase sequencer and
// frontplane/backplane level generation with low power handling
// assumes control inputs synchronous to core_clk_in; bias voltages are
// made outside from the 2-bit level codes, oe low means high impedance
`timescale 1ns/1ns
`include "seg_display_params.svh"

module segment_display_driver #(
  parameter int BASE_DIVIDE = `SEG_BASE_DIVIDE
) (
  input  wire logic        core_clk_in,
  input  wire logic        rst_in,
  input  wire logic        display_driver_enable_in,
  input  wire logic [31:0] frontplane_output_enable_in,
  input  wire logic        duty_select_high_in,
  input  wire logic        duty_select_low_in,
  input  wire logic        bias_select_in,
  input  wire logic [2:0]  display_clock_prescale_in,
  input  wire logic        stop_in_wait_in,
  input  wire logic        run_in_pseudo_stop_in,
  input  wire logic        wait_mode_in,
  input  wire logic        pseudo_stop_mode_in,
  input  wire logic        stop_mode_in,
  input  wire logic [3:0]  mem_addr_in,
  input  wire logic        mem_write_in,
  input  wire logic        mem_read_in,
  input  wire logic [7:0]  mem_wdata_in,
  output logic      [7:0]  mem_rdata_out,
  output logic      [7:0]  backplane_outputs_out,
  output logic      [3:0]  backplane_oe_out,
  output logic      [63:0] frontplane_outputs_out,
  output logic      [31:0] frontplane_oe_out
);

  // ---- decoding helpers ----
  // number of active backplanes for a duty code
  function automatic logic [2:0] bp_count(
    input seg_display_pkg::duty_type d
  );
    case (d)
      seg_display_pkg::DUTY_ONE:   bp_count = 3'd1;
      seg_display_pkg::DUTY_HALF:  bp_count = 3'd2;
      seg_display_pkg::DUTY_THIRD: bp_count = 3'd3;
      default:                     bp_count = 3'd4;
    endcase
  endfunction

  // bias actually applied for duty and bias bit
  function automatic seg_display_pkg::bias_type bias_of(
    input seg_display_pkg::duty_type d,
    input logic                      b
  );
    if (d == seg_display_pkg::DUTY_ONE) begin
      bias_of = seg_display_pkg::BIAS_FULL;
    end else if (d == seg_display_pkg::DUTY_HALF && !b) begin
      bias_of = seg_display_pkg::BIAS_HALF;
    end else begin
      bias_of = seg_display_pkg::BIAS_THIRD;
    end
  endfunction

  // backplane level: full swing when selected or at full bias, mid levels otherwise
  function automatic seg_display_pkg::level_type bp_level(
    input logic                      sel,
    input logic                      pol,
    input seg_display_pkg::bias_type bias
  );
    if (sel || bias == seg_display_pkg::BIAS_FULL) begin
      bp_level = pol ? seg_display_pkg::LEVEL_V0
                     : seg_display_pkg::LEVEL_V3;
    end else if (bias == seg_display_pkg::BIAS_HALF) begin
      bp_level = seg_display_pkg::LEVEL_V1;
    end else begin
      bp_level = pol ? seg_display_pkg::LEVEL_V2
                     : seg_display_pkg::LEVEL_V1;
    end
  endfunction

  // frontplane level: opposite of selected backplane when segment is on
  function automatic seg_display_pkg::level_type fp_level(
    input logic                      on,
    input logic                      pol,
    input seg_display_pkg::bias_type bias
  );
    if (on) begin
      fp_level = pol ? seg_display_pkg::LEVEL_V3
                     : seg_display_pkg::LEVEL_V0;
    end else if (bias == seg_display_pkg::BIAS_THIRD) begin
      fp_level = pol ? seg_display_pkg::LEVEL_V1
                     : seg_display_pkg::LEVEL_V2;
    end else begin
      fp_level = pol ? seg_display_pkg::LEVEL_V0
                     : seg_display_pkg::LEVEL_V3;
    end
  endfunction

  // ---- captured controls ----
  seg_display_pkg::duty_type duty;
  logic                      bias_bit;
  logic                      enable;
  logic [31:0]               fp_enable;
  logic [2:0]                prescale;
  logic                      stop_in_wait;
  logic                      run_in_pseudo_stop;

  // control capture with documented reset state
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      duty               <= seg_display_pkg::duty_type'(`SEG_DUTY_RESET);
      bias_bit           <= `SEG_BIAS_RESET;
      enable             <= 1'b0;
      fp_enable          <= `SEG_FP_EN_RESET;
      prescale           <= `SEG_PRESCALE_RESET;
      stop_in_wait       <= 1'b0;
      run_in_pseudo_stop <= 1'b0;
    end else begin
      duty <= seg_display_pkg::duty_type'(
                {duty_select_high_in, duty_select_low_in});
      bias_bit           <= bias_select_in;
      enable             <= display_driver_enable_in;
      fp_enable          <= frontplane_output_enable_in;
      prescale           <= display_clock_prescale_in;
      stop_in_wait       <= stop_in_wait_in;
      run_in_pseudo_stop <= run_in_pseudo_stop_in;
    end
  end

  // ---- mode decode ----
  logic                      driver_off;
  logic                      run;
  logic [2:0]                num_bp;
  seg_display_pkg::bias_type bias;
  logic                      tick;

  // low power shutdown: clocks held, state kept for resume
  assign driver_off = stop_mode_in
                   || (wait_mode_in && stop_in_wait)
                   || (pseudo_stop_mode_in && !run_in_pseudo_stop);
  assign run    = enable && !driver_off;
  assign num_bp = bp_count(duty);
  assign bias   = bias_of(duty, bias_bit);

  seg_clock_prescaler #(
    .BASE_DIVIDE (BASE_DIVIDE)
  ) u_prescaler (
    .core_clk_in (core_clk_in),
    .rst_in      (rst_in),
    .run_in      (run),
    .prescale_in (prescale),
    .tick_out    (tick)
  );

  // ---- segment memory ----
  logic [127:0] seg_bits;

  seg_segment_memory u_memory (
    .core_clk_in  (core_clk_in),
    .rst_in       (rst_in),
    .addr_in      (mem_addr_in),
    .write_in     (mem_write_in),
    .read_in      (mem_read_in),
    .wdata_in     (mem_wdata_in),
    .rdata_out    (mem_rdata_out),
    .seg_bits_out (seg_bits)
  );

  // ---- phase sequencer ----
  logic [1:0] phase;
  logic       polarity;
  logic       last_phase;

  assign last_phase = ({1'b0, phase} >= (num_bp - 3'd1));

  // one phase per display clock, polarity flips each frame
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      phase    <= 2'h0;
      polarity <= 1'b0;
    end else if (!enable) begin
      phase    <= 2'h0;
      polarity <= 1'b0;
    end else if (tick) begin
      if (last_phase) begin
        phase    <= 2'h0;
        polarity <= !polarity;
      end else begin
        phase <= phase + 2'h1;
      end
    end else if ({1'b0, phase} >= num_bp) begin
      // a duty change that leaves phase beyond the shrunken frame restarts it at once
      phase <= 2'h0;
    end
  end

  // ---- next pin levels ----
  logic [7:0]  next_bp_level;
  logic [3:0]  next_bp_oe;
  logic [63:0] next_fp_level;
  logic [31:0] next_fp_oe;

  // backplanes depend on phase, polarity, duty, bias and the enable and low power state
  for (genvar k = 0; k < `SEG_BP_COUNT; k++) begin : g_bp
    logic used;
    assign used = (k < num_bp);
    assign next_bp_oe[k] = enable && used;
    assign next_bp_level[2*k +: 2] = driver_off
      ? seg_display_pkg::LEVEL_V0
      : bp_level(phase == 2'(k), polarity, bias);
  end

  // frontplanes pick their nibble bit for the current phase
  for (genvar j = 0; j < `SEG_FP_COUNT; j++) begin : g_fp
    logic on;
    assign on = seg_bits[`SEG_NIBBLE_W*j + phase];
    assign next_fp_oe[j] = enable && fp_enable[j];
    assign next_fp_level[2*j +: 2] = driver_off
      ? seg_display_pkg::LEVEL_V0
      : fp_level(on, polarity, bias);
  end

  // registered pin outputs
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      backplane_outputs_out  <= 8'h00;
      backplane_oe_out       <= 4'h0;
      frontplane_outputs_out <= 64'h0;
      frontplane_oe_out      <= 32'h0;
    end else begin
      backplane_outputs_out  <= next_bp_level;
      backplane_oe_out       <= next_bp_oe;
      frontplane_outputs_out <= next_fp_level;
      frontplane_oe_out      <= next_fp_oe;
    end
  end

  // ---- checks ----
  chk_unused_bp_off: assert property (@(posedge core_clk_in)
    disable iff (rst_in)
    (duty == seg_display_pkg::DUTY_HALF) |=> (backplane_oe_out[3:2] == 2'b00))
    else $error("unused backplane driven at half duty");

  chk_fp_gated: assert property (@(posedge core_clk_in)
    disable iff (rst_in) !enable |=> (frontplane_oe_out == 32'h0))
    else $error("frontplane driven while global enable clear");

  chk_fp_appears: assert property (@(posedge core_clk_in)
    disable iff (rst_in)
    (enable && fp_enable[5]) |=> frontplane_oe_out[5])
    else $error("enabled frontplane not driven");

  chk_lowpower_ground: assert property (@(posedge core_clk_in)
    disable iff (rst_in)
    driver_off |=> (frontplane_outputs_out == 64'h0
                    && backplane_outputs_out == 8'h00))
    else $error("pins not grounded in low power mode");

  chk_phase_range: assert property (@(posedge core_clk_in)
    disable iff (rst_in)
    (enable && $stable(duty)) |=> ({1'b0, phase} < num_bp || $changed(duty)))
    else $error("phase beyond active backplanes");

  chk_frame_wrap: assert property (@(posedge core_clk_in)
    disable iff (rst_in)
    (enable && tick && last_phase) |=> (phase == 2'h0
                                        && polarity != $past(polarity)))
    else $error("frame did not wrap with polarity change");

  chk_on_segment: assert property (@(posedge core_clk_in)
    disable iff (rst_in)
    (!driver_off && seg_bits[phase]) |=>
      (frontplane_outputs_out[1:0] == ($past(polarity) ? 2'b11 : 2'b00)))
    else $error("on segment level wrong");

  chk_off_segment: assert property (@(posedge core_clk_in)
    disable iff (rst_in)
    (!driver_off && !seg_bits[phase]
     && bias == seg_display_pkg::BIAS_THIRD) |=>
      (frontplane_outputs_out[1:0] inside {2'b01, 2'b10}))
    else $error("off segment level wrong at third bias");

  chk_bias_full: assert property (@(posedge core_clk_in)
    disable iff (rst_in)
    (duty == seg_display_pkg::DUTY_ONE)
    |=> (frontplane_outputs_out[1:0] inside {2'b00, 2'b11}))
    else $error("single backplane duty without full bias");

endmodule // segment_display_driver

// ===== verif/seg_glass_model.sv
// glass model: field across the eight segments of frontplanes 0 and 1
// assumes 2-bit level codes and oe low meaning a floating pin
`timescale 1ns/1ns

module seg_glass_model (
  input  wire logic [7:0]  bp_lvl_in,
  input  wire logic [3:0]  bp_oe_in,
  input  wire logic [3:0]  fp_lvl_in,
  input  wire logic [1:0]  fp_oe_in,
  output logic      [15:0] diff_out
);
  logic [1:0] b;
  logic [1:0] f;

  // difference in level steps; a floating side gives no field
  always_comb begin
    diff_out = 16'h0;
    b = 2'h0;
    f = 2'h0;
    for (int s = 0; s < 8; s++) begin
      b = bp_lvl_in[2 * (s % 4) +: 2];
      f = fp_lvl_in[2 * (s / 4) +: 2];
      if (bp_oe_in[s % 4] && fp_oe_in[s / 4])
        diff_out[2 * s +: 2] = (b > f) ? b - f : f - b;
    end
  end
endmodule // seg_glass_model

// ===== verif/segment_display_driver_bench.sv
// bench for the segment display driver with a glass model on two pins
// assumes the divider shortened to 4 oscillator cycles per display clock
`timescale 1ns/1ns

module segment_display_driver_bench;
  localparam int DIV = 4;
  localparam logic [7:0] PAT = 8'h5a;
  logic        clk = 1'b0, rst = 1'b1, en = 1'b0, dh = 1'b0, dl = 1'b0;
  logic        bias = 1'b0, swai = 1'b0, rpstp = 1'b0, wt = 1'b0;
  logic        ps = 1'b0, stp = 1'b0, wr = 1'b0, rd = 1'b0;
  logic [31:0] fpen = 32'h0;
  logic [2:0]  pre = 3'h0;
  logic [3:0]  addr = 4'h0;
  logic [7:0]  wdata = 8'h0;
  logic [7:0]  rdata, bpl;
  logic [3:0]  bpoe;
  logic [63:0] fpl;
  logic [31:0] fpoe;
  logic [15:0] diff;
  int          err_total = 0;
  int          num_checks = 0;

  // 50 MHz clock
  always #10 clk = ~clk;

  segment_display_driver #(.BASE_DIVIDE(DIV)) segment_display_driver_i (
    .core_clk_in(clk), .rst_in(rst), .display_driver_enable_in(en),
    .frontplane_output_enable_in(fpen), .duty_select_high_in(dh),
    .duty_select_low_in(dl), .bias_select_in(bias),
    .display_clock_prescale_in(pre), .stop_in_wait_in(swai),
    .run_in_pseudo_stop_in(rpstp), .wait_mode_in(wt),
    .pseudo_stop_mode_in(ps), .stop_mode_in(stp), .mem_addr_in(addr),
    .mem_write_in(wr), .mem_read_in(rd), .mem_wdata_in(wdata),
    .mem_rdata_out(rdata), .backplane_outputs_out(bpl),
    .backplane_oe_out(bpoe), .frontplane_outputs_out(fpl),
    .frontplane_oe_out(fpoe));

  seg_glass_model seg_glass_model_i (
    .bp_lvl_in(bpl), .bp_oe_in(bpoe), .fp_lvl_in(fpl[3:0]),
    .fp_oe_in(fpoe[1:0]), .diff_out(diff));

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic mem_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic mem_chk(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 check(rdata, d);
  endtask

  task automatic set_mode(input logic [1:0] d, input logic b);
    @(posedge clk);
    dh <= d[1];
    dl <= d[0];
    bias <= b;
    tick(3);
  endtask

  task automatic t_reset();
    tick(5);
    check({bpl, bpoe, fpoe}, 64'h0);
    check(fpl, 64'h0);
    @(posedge clk);
    rst <= 1'b0;
    en <= 1'b1;
    fpen <= 32'h1;
    tick(3);
    check({bpoe, fpoe}, {4'hf, 32'h1});
  endtask

  task automatic t_memory();
    @(posedge clk);
    en <= 1'b0;
    for (int a = 0; a < 16; a++) mem_wr(a[3:0], {a[3:0], ~a[3:0]});
    @(posedge clk);
    en <= 1'b1;
    for (int a = 0; a < 16; a++) mem_chk(a[3:0], {a[3:0], ~a[3:0]});
  endtask

  task automatic t_duty();
    logic [3:0] mask [4] = '{4'hf, 4'h1, 4'h3, 4'h7};
    @(posedge clk);
    fpen <= 32'hffff_ffff;
    for (int d = 0; d < 4; d++) begin
      set_mode(d[1:0], 1'b0);
      check(bpoe, mask[d]);
      check(fpoe, 32'hffff_ffff);
    end
  endtask

  task automatic t_enable();
    @(posedge clk);
    en <= 1'b0;
    fpen <= 32'h3;
    tick(3);
    check({bpoe, fpoe}, 64'h0);
    @(posedge clk);
    en <= 1'b1;
    tick(3);
    check(fpoe, 64'h3);
    @(posedge clk);
    fpen <= 32'h8000_0003;
    tick(2);
    check(fpoe, 64'h8000_0003);
  endtask

  task automatic t_segments();
    logic [8:0] tbl [6] = '{9'h084, 9'h0c4, 9'h10e, 9'h14d, 9'h19d, 9'h07d};
    logic [1:0] mx [8];
    logic [1:0] ex;
    mem_wr(4'h0, PAT);
    for (int m = 0; m < 6; m++) begin
      set_mode(tbl[m][8:7], tbl[m][6]);
      tick(40);
      mx = '{default: 2'h0};
      repeat (40) begin
        for (int s = 0; s < 8; s++)
          if (diff[2 * s +: 2] > mx[s]) mx[s] = diff[2 * s +: 2];
        tick(1);
      end
      for (int s = 0; s < 8; s++) begin
        ex = !tbl[m][2 + s % 4] ? 2'h0 : PAT[s] ? 2'h3 : tbl[m][1:0];
        check(mx[s], ex);
      end
    end
  endtask

  // each entry: wait, stop-in-wait, pseudo stop, run bit, stop, off
  task automatic t_lowpower();
    logic [5:0] tbl [6] = '{6'h20, 6'h31, 6'h09, 6'h0c, 6'h03, 6'h10};
    logic [71:0] last;
    int act, lit;
    set_mode(2'h0, 1'b1);
    for (int m = 0; m < 6; m++) begin
      @(posedge clk);
      {wt, swai, ps, rpstp, stp} <= tbl[m][5:1];
      tick(2);
      act = 0;
      lit = 0;
      last = {bpl, fpl};
      repeat (20) begin
        act += ({bpl, fpl} !== last);
        lit += ({bpl, fpl} !== 72'h0);
        last = {bpl, fpl};
        tick(1);
      end
      if (tbl[m][0])
        check(lit, 0);
      else
        check(act > 0, 1);
      check({bpoe, fpoe}, {4'hf, 32'h8000_0003});
    end
    @(posedge clk);
    {wt, swai, ps, rpstp, stp} <= 5'h0;
    mem_chk(4'h0, PAT);
  endtask

  // cycles from one entry of backplane 0 into the top level to the next
  task automatic to_v3(output int c);
    c = 0;
    while (bpl[1:0] === 2'h3 && c < 3000) begin
      tick(1);
      c++;
    end
    while (bpl[1:0] !== 2'h3 && c < 3000) begin
      tick(1);
      c++;
    end
  endtask

  task automatic period(input int nbp, input int code);
    int c;
    tick(1);
    to_v3(c);
    to_v3(c);
    to_v3(c);
    check(c, 2 * nbp * (DIV << code));
  endtask

  // prescale only rises here so the divider never overshoots its limit
  task automatic t_rate();
    int nbp [4] = '{4, 1, 2, 3};
    for (int d = 0; d < 4; d++) begin
      set_mode(d[1:0], 1'b0);
      period(nbp[d], 0);
    end
    set_mode(2'h1, 1'b0);
    for (int p = 1; p < 8; p++) begin
      @(posedge clk);
      pre <= p[2:0];
      period(1, p);
    end
  endtask

  task automatic results();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // main sequence
  initial begin
    t_reset();
    t_memory();
    t_duty();
    t_enable();
    t_segments();
    t_lowpower();
    t_rate();
    results();
  end

  // watchdog: 20000 cycles, near three times the expected run
  initial begin
    #400_000;
    err_total++;
    results();
  end
endmodule // segment_display_driver_bench
